// [an_exp_pkg.sv]
package an_exp_pkg;
    localparam logic [7:0] SEL_REG_ADDR = 8'h6E;
    localparam logic [7:0] OFS_REG_ADDR = 8'h6F;
    localparam logic [7:0] DATA_WIN_ADDR = 8'hA0;
    localparam logic [2:0] FUNC_EEE = 3'h1;
    localparam logic [3:0] PORT_FIRST = 4'h3;
    localparam logic [3:0] PORT_LAST = 4'h4;
    localparam logic [7:0] OFS_EXP_HI = 8'h0C;
    localparam logic [7:0] OFS_EXP_LO = 8'h0D;
    localparam int BIT_LOC_ABLE = 6;
    localparam int BIT_LOC_SEL = 5;
    localparam int BIT_PD_FAULT = 4;
    localparam int BIT_LP_NP = 3;
    localparam int BIT_NP_ABLE = 2;
    localparam int BIT_PAGE_RX = 1;
    localparam int BIT_LP_AN = 0;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] OFS_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam int NPORTS = 2;

    typedef struct packed {
        logic pd_fault;
        logic page_rx;
        logic lp_np_able;
        logic lp_an_able;
    } port_status_s;
endpackage : an_exp_pkg

// [autoneg_expansion_status_reg.sv]
// Summary of operation
// - Offset 0x0C high, 0x0D low, via 0xA0
// - Bit 6 reads constant one
// - Bit 5 reads one: pages in 8h
// - Parallel detection fault latches high, reset zero
// - Reading fault bit returns it, then clears
// - Bit 3 reports partner next-page ability
// - Bit 2 reports local next-page support, one
// - Page received latches high, reset zero
// - Bit 0 reports partner auto-negotiation ability
`timescale 1ns/1ps
module autoneg_expansion_status_reg
    import an_exp_pkg::*;
#(
    parameter logic LOC_SEL_8H = 1'b1,
    parameter logic LOCAL_NP_ABLE = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire port_status_s [NPORTS-1:0] port_ev
);
    // port_ev: pd_fault/page_rx are one-cycle events, the other two levels,
    // all from logic on this clock. Index 0 is port 3, index 1 is port 4.
    logic [7:0] sel_r, sel_nxt;
    logic [7:0] ofs_r, ofs_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [NPORTS-1:0] fault_r, fault_nxt;
    logic [NPORTS-1:0] prx_r, prx_nxt;
    logic [NPORTS-1:0] lpnp_r, lpnp_nxt;
    logic [NPORTS-1:0] lpan_r, lpan_nxt;

    function automatic logic [15:0] exp_word(input logic f, input logic p,
                                             input logic np, input logic an);
        logic [15:0] w;
        w = 16'h0000;
        w[BIT_LOC_ABLE] = 1'b1;
        w[BIT_LOC_SEL] = LOC_SEL_8H;
        w[BIT_PD_FAULT] = f;
        w[BIT_LP_NP] = np;
        w[BIT_NP_ABLE] = LOCAL_NP_ABLE;
        w[BIT_PAGE_RX] = p;
        w[BIT_LP_AN] = an;
        return w;
    endfunction : exp_word

    // Address decode, shared by the write and read paths
    function automatic logic hit(input logic strobe, input logic [7:0] a,
                                 input logic [7:0] target);
        return strobe && (a == target);
    endfunction : hit

    // The window only answers for the EEE group and one of the two copper ports
    function automatic logic sel_valid(input logic [7:0] s);
        logic grp_ok;
        logic port_ok;
        grp_ok = (s[7:5] == FUNC_EEE);
        port_ok = (s[3:0] >= PORT_FIRST) && (s[3:0] <= PORT_LAST);
        return grp_ok && port_ok;
    endfunction : sel_valid

    // Index 0 is port 3, index 1 is port 4
    function automatic logic [0:0] port_index(input logic [7:0] s);
        return (s[3:0] == PORT_LAST) ? 1'b1 : 1'b0;
    endfunction : port_index

    // Byte picked out of the status word by the offset register
    function automatic logic [7:0] win_byte(input logic ok, input logic [7:0] o,
                                            input logic [15:0] w);
        logic [7:0] b;
        b = 8'h00;
        if (ok && o == OFS_EXP_HI) begin
            b = w[15:8];
        end else if (ok && o == OFS_EXP_LO) begin
            b = w[7:0];
        end
        return b;
    endfunction : win_byte

    logic sel_ok;
    logic [0:0] pidx;
    logic win_rd;
    logic lo_rd;
    logic [15:0] word;

    assign sel_ok = sel_valid(sel_r);
    assign pidx = port_index(sel_r);
    assign win_rd = hit(rd_en, addr, DATA_WIN_ADDR) && sel_ok;
    assign lo_rd = win_rd && (ofs_r == OFS_EXP_LO);
    assign word = exp_word(fault_r[pidx], prx_r[pidx], lpnp_r[pidx], lpan_r[pidx]);

    // Select and offset registers
    always_comb begin
        sel_nxt = sel_r;
        ofs_nxt = ofs_r;
        if (hit(wr_en, addr, SEL_REG_ADDR)) begin
            sel_nxt = wdata;
        end
        if (hit(wr_en, addr, OFS_REG_ADDR)) begin
            ofs_nxt = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_r <= SEL_RESET;
            ofs_r <= OFS_RESET;
        end else begin
            sel_r <= sel_nxt;
            ofs_r <= ofs_nxt;
        end
    end

    // Read data stands until the next read strobe
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_en) begin
            case (addr)
                SEL_REG_ADDR: rdata_nxt = sel_r;
                OFS_REG_ADDR: rdata_nxt = ofs_r;
                DATA_WIN_ADDR: rdata_nxt = win_byte(sel_ok, ofs_r, word);
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= RDATA_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Latched events: clear on a low-byte read; a new event in that cycle wins
    always_comb begin
        fault_nxt = fault_r;
        prx_nxt = prx_r;
        for (int i = 0; i < NPORTS; i++) begin
            if (lo_rd && pidx == i[0:0]) begin
                fault_nxt[i] = 1'b0;
                prx_nxt[i] = 1'b0;
            end
            if (port_ev[i].pd_fault) begin
                fault_nxt[i] = 1'b1;
            end
            if (port_ev[i].page_rx) begin
                prx_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fault_r <= '0;
            prx_r <= '0;
        end else begin
            fault_r <= fault_nxt;
            prx_r <= prx_nxt;
        end
    end

    // Partner abilities are plain levels, registered once
    always_comb begin
        lpnp_nxt = lpnp_r;
        lpan_nxt = lpan_r;
        for (int i = 0; i < NPORTS; i++) begin
            lpnp_nxt[i] = port_ev[i].lp_np_able;
            lpan_nxt[i] = port_ev[i].lp_an_able;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lpnp_r <= '0;
            lpan_r <= '0;
        end else begin
            lpnp_r <= lpnp_nxt;
            lpan_r <= lpan_nxt;
        end
    end

    // Output comes straight from the read data register
    assign rdata = rdata_r;

endmodule : autoneg_expansion_status_reg

// [autoneg_expansion_status_reg_asserts.sv]
`timescale 1ns/1ps
module an_exp_chk
    import an_exp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire port_status_s [NPORTS-1:0] port_ev
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire ev = |{port_ev[0].pd_fault, port_ev[1].pd_fault, port_ev[0].page_rx, port_ev[1].page_rx};
    wire win = rd_en && !wr_en && addr == DATA_WIN_ADDR;
    sequence s_quiet; win && !ev; endsequence
    sequence s_wsel; wr_en && addr == SEL_REG_ADDR; endsequence
    sequence s_wofs; wr_en && addr == OFS_REG_ADDR; endsequence
    sequence s_gap; !ev && !wr_en; endsequence
    logic [7:0] sel_m;
    logic [7:0] ofs_m;
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_m <= 8'h00;
            ofs_m <= 8'h00;
        end else begin
            if (wr_en && addr == SEL_REG_ADDR) begin
                sel_m <= wdata;
            end
            if (wr_en && addr == OFS_REG_ADDR) begin
                ofs_m <= wdata;
            end
        end
    end
    property p_hold; !rd_en |=> $stable(rdata); endproperty
    property p_unmap; rd_en && !(addr inside {8'h6E, 8'h6F, 8'hA0}) |=> rdata == 8'h00; endproperty
    property p_sel; (rd_en && !wr_en && addr == SEL_REG_ADDR) |=> rdata == $past(sel_m); endproperty
    property p_ofs; (rd_en && !wr_en && addr == OFS_REG_ADDR) |=> rdata == $past(ofs_m); endproperty
    property p_fmt; win |=> !rdata[7] && (rdata == 8'h00 || (rdata[6:5] == 2'b11 && rdata[2])); endproperty
    property p_fclr; s_quiet ##1 s_gap ##1 s_quiet |=> !rdata[BIT_PD_FAULT]; endproperty
    property p_pclr; s_quiet ##1 s_gap ##1 s_quiet |=> !rdata[BIT_PAGE_RX]; endproperty
    property p_lvl; win |=> !rdata[0] || $past(port_ev[0].lp_an_able | port_ev[1].lp_an_able, 2); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved without read");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_sel: assert property (p_sel) else $error("select readback wrong");
    a_ofs: assert property (p_ofs) else $error("offset readback wrong");
    a_fmt: assert property (p_fmt) else $error("fixed bits wrong");
    a_fclr: assert property (p_fclr) else $error("fault not cleared");
    a_pclr: assert property (p_pclr) else $error("page flag not cleared");
    a_lvl: assert property (p_lvl) else $error("partner ability without cause");
endmodule : an_exp_chk
bind autoneg_expansion_status_reg an_exp_chk u_an_exp_chk (.clk(clk), .rst(rst), .addr(addr),
    .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .port_ev(port_ev));

// [test_autoneg_expansion_status_reg.sv]
`timescale 1ns/1ps
module test_autoneg_expansion_status_reg;
    import an_exp_pkg::*;
    logic clk = 0, rst = 1, wr_en = 0, rd_en = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, v, sel, ofs;
    logic [3:0] ev;
    port_status_s [NPORTS-1:0] port_ev = '0;
    logic [1:0] f = 0, p = 0;
    int error_cnt = 0, checks = 0, pi;
    always #2 clk = ~clk;
    autoneg_expansion_status_reg u_autoneg_expansion_status_reg (.clk(clk), .rst(rst),
        .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .port_ev(port_ev));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value rdata expected %h seen %h", e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask : rd
    // Model of the selected byte; a low-byte read of a valid port clears its latches
    function automatic logic [7:0] expect_win();
        int i;
        i = int'(sel[3:0]) - 3;
        expect_win = 8'h00;
        if (sel[7:5] == FUNC_EEE && sel[3:0] inside {[PORT_FIRST:PORT_LAST]} && ofs == OFS_EXP_LO) begin
            expect_win = {3'b011, f[i], port_ev[i].lp_np_able, 1'b1, p[i], port_ev[i].lp_an_able};
            f[i] = 1'b0;
            p[i] = 1'b0;
        end
    endfunction : expect_win
    task automatic results();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    initial begin
        #40000;
        error_cnt++;
        results();
    end
    initial begin
        void'($urandom(32'hB4A53B7F));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(SEL_REG_ADDR);
        chk(v, 8'h00);
        rd(8'h55);
        chk(v, 8'h00);
        $display("test reset done");
        for (int n = 0; n < 60; n++) begin
            sel = {($urandom % 4 == 0) ? 3'h2 : FUNC_EEE, 1'b0, 4'h2 + 4'($urandom % 4)};
            ofs = ($urandom % 5 == 0) ? 8'h0E : OFS_EXP_HI + 8'($urandom % 2);
            pi = $urandom % 2;
            ev = 4'($urandom);
            @(posedge clk);
            port_ev[pi] <= ev;
            f[pi] = f[pi] | ev[3];
            p[pi] = p[pi] | ev[2];
            @(posedge clk);
            port_ev[pi] <= {2'b00, ev[1:0]};
            wr(SEL_REG_ADDR, sel);
            wr(OFS_REG_ADDR, ofs);
            wr(DATA_WIN_ADDR, 8'hFF);
            rd(SEL_REG_ADDR);
            chk(v, sel);
            for (int k = 0; k < 2; k++) begin
                rd(DATA_WIN_ADDR);
                chk(v, expect_win());
            end
        end
        $display("test random done");
        results();
    end
endmodule : test_autoneg_expansion_status_reg
